/* File: core/synth_defines.svh */
// field positions, codes and reset values of the synthesizer control latches
// assumes a 32-bit word per latch, control field in the low bits
`ifndef SYNTH_DEFINES_SVH
`define SYNTH_DEFINES_SVH

`define SYN_NUM_LATCH     6
`define SYN_WORD_BITS     32
`define SYN_ADDR_HI       2
`define SYN_ADDR_LO       0
`define SYN_LATCH_RST     32'h0000_0000

`define SYN_REG_FREQ      3'h0
`define SYN_REG_MODPH     3'h1
`define SYN_REG_MISC      3'h2
`define SYN_REG_RESYNC    3'h3

`define SYN_MODE_HI       16
`define SYN_MODE_LO       15
`define SYN_MODE_RESYNC   2'h2

`define SYN_DIV_HI        14
`define SYN_DIV_LO        3
`define SYN_MOD_HI        14
`define SYN_MOD_LO        3
`define SYN_PHASE_HI      26
`define SYN_PHASE_LO      15

`define SYN_DITHER_BIT    29
`define SYN_STAT_HI       28
`define SYN_STAT_LO       26
`define SYN_STAT_LOCK     3'h6

`endif

/* File: core/synth_pkg.sv */
// types shared by the synthesizer serial load and phase resync logic
// assumes the constants header for field positions
package synth_pkg;
    typedef struct packed {
        logic [1:0]  mode;
        logic [11:0] clk_div;
    } resync_cfg_s;

    typedef enum logic [2:0] {
        RS_IDLE   = 3'b001,
        RS_FIRST  = 3'b010,
        RS_SECOND = 3'b100
    } resync_state_e;
endpackage

/* File: core/synth_serial_load_phase_resync.sv */
// serial latch loader, resync timer, phase seed and status output of the synthesizer
// assumes every pin input is asynchronous to mclk and far slower than it
`timescale 1ns/1ps
`include "synth_defines.svh"

// Summary of operation
// R1: resync on when mode field is one-zero
// R2: sync period is divider times modulus times reference
// R3: divider from resync latch, range 1 to 4095
// R4: modulus from latch one bits 14:3
// R5: realign on second sync after strobe rise
// R6: host keeps interval above loop settling time
// R7: phase word sets output phase in modulus steps
// R8: without dither, phase word seeds the modulator
// R9: host keeps phase word fixed without lookup
// R10: shift on rising serial clock, latch on strobe
// R11: host sends one 32-bit word per strobe
// R12: host uses clock phase zero
// R13: host writes latches five down to zero
// R14: chip enable and multiplexed status output
// R15: low three bits select the latch
// R16: words arrive most significant bit first
module synth_serial_load_phase_resync (
    input  wire logic                        mclk,
    input  wire logic                        rst,
    input  wire logic                        ser_clk,
    input  wire logic                        ser_data,
    input  wire logic                        latch_strobe,
    input  wire logic                        ref_clk,
    input  wire logic                        chip_enable,
    input  wire logic                        lock_detect,
    output logic [`SYN_NUM_LATCH-1:0][31:0]  latch_r,
    output logic                             resync_active_r,
    output logic                             sync_pulse_r,
    output logic                             realign_pulse_r,
    output logic [11:0]                      phase_word_r,
    output logic [11:0]                      sdm_seed_r,
    output logic                             sdm_seed_load_r,
    output logic                             multiplexed_status_output,
    output logic                             power_down_r
);
    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [5:0] pin_s1_r;
    logic [5:0] pin_s2_r;
    logic [2:0] pin_d_r;
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            // strobe idles high: its stages reset high so no false commit follows reset
            pin_s1_r <= 6'h04;
            pin_s2_r <= 6'h04;
            pin_d_r  <= 3'h2;
        end else begin
            pin_s1_r <= {lock_detect, chip_enable, ref_clk, latch_strobe, ser_data, ser_clk};
            pin_s2_r <= pin_s1_r;
            pin_d_r  <= pin_s2_r[3:0] == 4'h0 ? 3'h0 : {pin_s2_r[3], pin_s2_r[2], pin_s2_r[0]};
        end
    end

    wire sclk_rise = pin_s2_r[0] & ~pin_d_r[0];
    wire data_s    = pin_s2_r[1];
    wire le_rise   = pin_s2_r[2] & ~pin_d_r[1];
    wire ref_rise  = pin_s2_r[3] & ~pin_d_r[2];
    wire ce_s      = pin_s2_r[4];
    wire lock_s    = pin_s2_r[5];

    // ------------------------------------------------------------
    // serial shift register and latches
    // ------------------------------------------------------------
    logic [31:0] shift_r;
    wire  [2:0]  word_addr = shift_r[`SYN_ADDR_HI:`SYN_ADDR_LO];
    wire         addr_ok   = word_addr < 3'(`SYN_NUM_LATCH);
    wire         freq_load = le_rise & (word_addr == `SYN_REG_FREQ);

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            shift_r <= `SYN_LATCH_RST;
        end else if (sclk_rise) begin
            shift_r <= {shift_r[30:0], data_s};  // [R10] [R12] [R16]
        end
    end

    // extra bits beyond 32 simply fall off the top, so only the last word counts
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            latch_r <= {`SYN_NUM_LATCH{`SYN_LATCH_RST}};
        end else if (le_rise && addr_ok) begin
            latch_r[word_addr] <= shift_r;  // [R10] [R11] [R15]
        end
    end

    // ------------------------------------------------------------
    // field decode
    // ------------------------------------------------------------
    synth_pkg::resync_cfg_s cfg;
    assign cfg.mode    = latch_r[`SYN_REG_RESYNC][`SYN_MODE_HI:`SYN_MODE_LO];
    assign cfg.clk_div = latch_r[`SYN_REG_RESYNC][`SYN_DIV_HI:`SYN_DIV_LO];  // [R3]
    wire [11:0] mod_w   = latch_r[`SYN_REG_MODPH][`SYN_MOD_HI:`SYN_MOD_LO];  // [R4]
    wire [11:0] phase_w = latch_r[`SYN_REG_MODPH][`SYN_PHASE_HI:`SYN_PHASE_LO];
    wire        dither  = latch_r[`SYN_REG_MISC][`SYN_DITHER_BIT];
    wire [2:0]  stat_w  = latch_r[`SYN_REG_MISC][`SYN_STAT_HI:`SYN_STAT_LO];
    wire        resync_en = (cfg.mode == `SYN_MODE_RESYNC) & ce_s;  // [R1]

    // ------------------------------------------------------------
    // resync timer: modulus counter inside divider counter
    // ------------------------------------------------------------
    function automatic logic at_last(input logic [11:0] cnt, input logic [11:0] lim);
        at_last = cnt >= 12'(lim - 12'h001);
    endfunction

    logic [11:0] mod_cnt_r;
    logic [11:0] div_cnt_r;
    wire mod_wrap  = at_last(mod_cnt_r, mod_w);
    wire div_wrap  = at_last(div_cnt_r, cfg.clk_div);
    // a zero divider or modulus gives no pulses at all
    wire cnt_ok    = (cfg.clk_div != 12'h000) & (mod_w != 12'h000);  // [R3]
    wire sync_tick = resync_en & cnt_ok & ref_rise & mod_wrap & div_wrap;  // [R2]

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            mod_cnt_r <= 12'h000;
            div_cnt_r <= 12'h000;
        end else if (!resync_en || !cnt_ok) begin
            mod_cnt_r <= 12'h000;
            div_cnt_r <= 12'h000;
        end else if (ref_rise) begin
            mod_cnt_r <= mod_wrap ? 12'h000 : 12'(mod_cnt_r + 12'h001);  // [R2] [R4]
            if (mod_wrap) begin
                div_cnt_r <= div_wrap ? 12'h000 : 12'(div_cnt_r + 12'h001);
            end
        end
    end

    // ------------------------------------------------------------
    // realignment sequencer
    // ------------------------------------------------------------
    synth_pkg::resync_state_e st_r;
    synth_pkg::resync_state_e st_nxt;
    always_comb begin
        st_nxt = st_r;
        case (st_r)
            synth_pkg::RS_IDLE:   st_nxt = st_r;
            synth_pkg::RS_FIRST:  if (sync_tick) st_nxt = synth_pkg::RS_SECOND;
            synth_pkg::RS_SECOND: if (sync_tick) st_nxt = synth_pkg::RS_IDLE;
            default:              st_nxt = synth_pkg::RS_IDLE;
        endcase
        // a fresh frequency load restarts the count of sync pulses
        if (freq_load) st_nxt = synth_pkg::RS_FIRST;  // [R5]
        if (!resync_en) st_nxt = synth_pkg::RS_IDLE;
    end
    wire realign_now = (st_r == synth_pkg::RS_SECOND) & sync_tick & resync_en & ~freq_load;  // [R5]

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            st_r            <= synth_pkg::RS_IDLE;
            resync_active_r <= 1'b0;
            sync_pulse_r    <= 1'b0;
            realign_pulse_r <= 1'b0;
        end else begin
            st_r            <= st_nxt;
            resync_active_r <= resync_en;  // [R1]
            sync_pulse_r    <= sync_tick;
            realign_pulse_r <= realign_now;
        end
    end

    // ------------------------------------------------------------
    // phase, modulator seed, power and status
    // ------------------------------------------------------------
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            phase_word_r              <= 12'h000;
            sdm_seed_r                <= 12'h000;
            sdm_seed_load_r           <= 1'b0;
            power_down_r              <= 1'b1;
            multiplexed_status_output <= 1'b0;
        end else begin
            phase_word_r    <= phase_w;  // [R7]
            sdm_seed_load_r <= freq_load & ~dither;  // [R8]
            if (freq_load && !dither) begin
                sdm_seed_r <= phase_w;  // [R8]
            end
            power_down_r              <= ~ce_s;  // [R14]
            multiplexed_status_output <= (stat_w == `SYN_STAT_LOCK) & lock_s & ce_s;  // [R14]
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    logic [23:0] ref_since_r;
    logic        clean_r;
    logic [1:0]  ticks_since_load_r;
    // sync pulses seen since the last frequency load, 3 = not armed
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ticks_since_load_r <= 2'h3;
        end else if (!resync_en) begin
            ticks_since_load_r <= 2'h3;
        end else if (freq_load) begin
            ticks_since_load_r <= 2'h0;
        end else if (sync_tick && ticks_since_load_r != 2'h3) begin
            ticks_since_load_r <= 2'(ticks_since_load_r + 2'h1);
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ref_since_r <= 24'h00_0000;
            clean_r     <= 1'b0;
        end else begin
            if (sync_tick || !resync_en) ref_since_r <= 24'h00_0000;
            else if (ref_rise) ref_since_r <= 24'(ref_since_r + 24'h00_0001);
            clean_r <= sync_tick ? 1'b1 : ((le_rise || !resync_en) ? 1'b0 : clean_r);
        end
    end

    a_sync_needs_mode: assert property (@(posedge mclk) disable iff (rst)  // [R1]
        sync_pulse_r |-> $past(cfg.mode) == `SYN_MODE_RESYNC && resync_active_r)
        else $error("sync pulse without resync mode");
    a_sync_period: assert property (@(posedge mclk) disable iff (rst)  // [R2]
        sync_tick && clean_r && !le_rise |-> 24'(ref_since_r + 24'h00_0001) == cfg.clk_div * mod_w)
        else $error("sync period differs from divider times modulus");
    a_div_zero_quiet: assert property (@(posedge mclk) disable iff (rst)  // [R3]
        cfg.clk_div == 12'h000 |-> !sync_tick)
        else $error("sync pulse with zero divider");
    a_mod_count_bound: assert property (@(posedge mclk) disable iff (rst)  // [R4]
        resync_en && cnt_ok && $stable(mod_w) |=> mod_cnt_r < mod_w || !$stable(mod_w))
        else $error("modulus counter beyond modulus");
    a_realign_second: assert property (@(posedge mclk) disable iff (rst)  // [R5]
        sync_tick && !freq_load && ticks_since_load_r == 2'h0 |=> !realign_pulse_r)
        else $error("realign on first sync pulse");
    a_realign_on_second: assert property (@(posedge mclk) disable iff (rst)  // [R5]
        sync_tick && !freq_load && ticks_since_load_r == 2'h1 |=> realign_pulse_r)
        else $error("no realign on second sync pulse");
    a_realign_cause: assert property (@(posedge mclk) disable iff (rst)  // [R5]
        realign_pulse_r |-> $past(st_r) == synth_pkg::RS_SECOND && sync_pulse_r)
        else $error("realign without second sync pulse");
    a_phase_follow: assert property (@(posedge mclk) disable iff (rst)  // [R7]
        le_rise && word_addr == `SYN_REG_MODPH |=> ##1 phase_word_r == $past(shift_r[`SYN_PHASE_HI:`SYN_PHASE_LO], 2))
        else $error("phase output not updated from latch one");
    a_seed_load: assert property (@(posedge mclk) disable iff (rst)  // [R8]
        freq_load && !dither |=> sdm_seed_load_r && sdm_seed_r == $past(phase_w))
        else $error("modulator seed not taken from phase word");
    a_latch_write: assert property (@(posedge mclk) disable iff (rst)  // [R10]
        le_rise && addr_ok |=> latch_r[$past(word_addr)] == $past(shift_r))
        else $error("latch not loaded from shift register");
    a_bad_addr_kept: assert property (@(posedge mclk) disable iff (rst)  // [R15]
        le_rise && !addr_ok && !$past(le_rise) |=> $stable(latch_r))
        else $error("latch changed on unmapped control field");
    a_status_lock: assert property (@(posedge mclk) disable iff (rst)  // [R14]
        multiplexed_status_output |-> $past(stat_w) == `SYN_STAT_LOCK && !power_down_r)
        else $error("status output high outside lock mode");
endmodule

/* File: verification/synth_host_model.sv */
// host serial master: shifts one word msb first and commits it with the strobe
// assumes the bench calls send() and nothing else drives the three pins
`timescale 1ns/1ps
module synth_host_model (
    output logic ser_clk,
    output logic ser_data,
    output logic latch_strobe
);
    // ----------------------------------------
    // word transfer
    // ----------------------------------------
    initial begin
        ser_clk      = 1'b0;
        ser_data     = 1'b0;
        latch_strobe = 1'b1;
    end

    // the clock stands still between words; data idles inverted so a stale bit never looks valid
    task automatic send(input logic [31:0] w);
        // half-step offset keeps every pin edge clear of a rising mclk edge
        #1.5;
        latch_strobe = 1'b0;
        for (int i = 31; i >= 0; i--) begin
            ser_data = w[i];
            #32 ser_clk = 1'b1;
            #32 ser_clk = 1'b0;
        end
        #32 latch_strobe = 1'b1;
        ser_data = ~w[0];
    endtask
endmodule

/* File: verification/synth_serial_load_phase_resync_test.sv */
// self-checking bench of the serial loader and resync timer
// assumes the host model drives the serial pins and a free-running reference
`timescale 1ns/1ps
`include "synth_defines.svh"
module synth_serial_load_phase_resync_test;
    logic                             mclk = 1'b0;
    logic                             rst, ref_clk = 1'b0, chip_enable, lock_detect;
    logic                             ser_clk, ser_data, latch_strobe;
    logic [3:0]                       strobe_q = 4'hf;
    logic [`SYN_NUM_LATCH-1:0][31:0]  latch_r, snap;
    logic                             resync_active_r, sync_pulse_r, realign_pulse_r;
    logic                             sdm_seed_load_r, multiplexed_status_output, power_down_r;
    logic [11:0]                      phase_word_r, sdm_seed_r, seed_seen = 12'h000;
    logic [31:0]                      sync_n = 0, realign_at = 0, seed_n = 0;
    real                              last_t = 0.0, prev_t = 0.0;
    int                               mismatches = 0, comparisons = 0;
    // host keeps the phase word fixed and the interval long enough
    logic [31:0] words [6] = '{32'h0058_0005, 32'h00A0_1234, 32'h0001_000B,
                               32'h1800_0002, 32'h0091_8011, 32'h0000_1230};

    always #2.5 mclk = ~mclk;
    always #32 ref_clk = ~ref_clk;

    synth_host_model u_synth_host_model (.ser_clk(ser_clk), .ser_data(ser_data), .latch_strobe(latch_strobe));

    synth_serial_load_phase_resync u_synth_serial_load_phase_resync (
        .mclk(mclk), .rst(rst), .ser_clk(ser_clk), .ser_data(ser_data), .latch_strobe(latch_strobe),
        .ref_clk(ref_clk), .chip_enable(chip_enable), .lock_detect(lock_detect), .latch_r(latch_r),
        .resync_active_r(resync_active_r), .sync_pulse_r(sync_pulse_r), .realign_pulse_r(realign_pulse_r),
        .phase_word_r(phase_word_r), .sdm_seed_r(sdm_seed_r), .sdm_seed_load_r(sdm_seed_load_r),
        .multiplexed_status_output(multiplexed_status_output), .power_down_r(power_down_r));

    // ----------------------------------------
    // monitors
    // ----------------------------------------
    // sync pulses are counted from the strobe rise as the design sees it, three stages late
    always @(posedge mclk) begin
        strobe_q <= {strobe_q[2:0], latch_strobe};
        if (strobe_q[2] && !strobe_q[3]) begin
            sync_n     <= 0;
            realign_at <= 0;
        end else if (sync_pulse_r) begin
            sync_n <= sync_n + 1;
            prev_t <= last_t;
            last_t <= $realtime;
            if (realign_pulse_r) realign_at <= sync_n + 1;
        end
        if (sdm_seed_load_r) begin
            seed_n    <= seed_n + 1;
            seed_seen <= sdm_seed_r;
        end
    end

    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    task automatic put(input logic [31:0] w);
        u_synth_host_model.send(w);
        repeat (8) @(posedge mclk);
    endtask

    // waits for three syncs after the strobe, then checks the gap of the last two
    task automatic check_period(input real p);
        for (int k = 0; k < 600 && sync_n < 3; k++) @(posedge mclk);
        check("sync_count", 32'(sync_n >= 3), 32'h0000_0001);
        check("sync_period", 32'(last_t - prev_t > p - 8.0 && last_t - prev_t < p + 8.0), 32'h1);
    endtask

    // ----------------------------------------
    // sequence
    // ----------------------------------------
    initial begin
        rst = 1'b1;
        chip_enable = 1'b1;
        lock_detect = 1'b0;
        repeat (3) @(posedge mclk);
        check("latch_rst", latch_r[3], 32'h0000_0000);
        check("pd_rst", 32'(power_down_r), 32'h0000_0001);
        #1.5 rst = 1'b0;
        repeat (4) @(posedge mclk);
        for (int i = 0; i < 6; i++) begin
            put(words[i]);
            check("latch", latch_r[words[i][2:0]], words[i]);
        end
        check("phase_word", 32'(phase_word_r), 32'h0000_0123);
        check("seed", 32'(seed_seen), 32'h0000_0123);
        check("resync_on", 32'(resync_active_r), 32'h0000_0001);
        check_period(128.0);
        check("realign", realign_at, 32'h0000_0002);
        put(32'h0001_001B);
        check_period(384.0);
        @(posedge mclk) #1.5 lock_detect = 1'b1;
        repeat (6) @(posedge mclk);
        check("status_hi", 32'(multiplexed_status_output), 32'h0000_0001);
        #1.5 lock_detect = 1'b0;
        repeat (6) @(posedge mclk);
        check("status_lo", 32'(multiplexed_status_output), 32'h0000_0000);
        snap = latch_r;
        put(32'hFFFF_FFF6);
        put(32'hFFFF_FFF7);
        check("bad_addr", 32'(latch_r === snap), 32'h0000_0001);
        put(32'h3800_0002);
        snap[0] = seed_n;
        put(words[5]);
        check("dither_seed", seed_n, snap[0]);
        put(32'h0000_800B);
        repeat (60) @(posedge mclk);
        check("mode_01", 32'(resync_active_r), 32'h0000_0000);
        check("no_sync", sync_n, 32'h0000_0000);
        put(32'h0001_000B);
        @(posedge mclk) #1.5 chip_enable = 1'b0;
        repeat (6) @(posedge mclk);
        check("pd", 32'(power_down_r), 32'h0000_0001);
        check("pd_resync", 32'(resync_active_r), 32'h0000_0000);
        finish_test();
    end

    initial begin
        #300000;
        mismatches++;
        finish_test();
    end
endmodule
